// file: hdl/asrc_pkg.sv
// Constants for the asynchronous 16-bit static RAM host controller.
// Assumes a single 50 MHz system clock; all pin timing is in whole clock cycles.
// Overview of operation
// [R1] Write enable stays high during every read.
// [R2] Address stable before chip select falls.
// [R3] Memory releases lane after lane control rises.
// [R4] Memory may drive lane immediately; release first.
// [R5] Write needs select, write enable, lane low.
// [R6] All strobes valid starts write; any ends.
// [R7] Data setup measured from write-ending edge.
// [R8] Write data stable before write-ending edge.
// [R9] Write data may change at ending edge.
// [R10] Address stable long before write ends.
// [R11] Address changes only after write-ending edge.
// [R12] Lane controls low long before write ends.
// [R13] Memory stops driving when write enable falls.
// [R14] Host releases bus soon after write ends; the host here drops its data driver one cycle (20 ns) after the ending edge.
// [R15] Write enable may span back-to-back writes.
// [R16] Output enable high before write enable falls.
// [R17] Deselected memory ignores controls, floats data.
// [R18] 262,144 words of 16 bits, two lanes.
// [R19] Read drives enabled lanes; write captures them.
// [R20] Space cycles; sample after access time.
// [R21] Old data held briefly after address changes.
package asrc_pkg;
    localparam int ADDR_W        = 18;
    localparam int DATA_W        = 16;
    localparam int LANES         = 2;
    localparam int CLK_PERIOD_PS = 20000;
    // Slowest grade, so any grade fitted is served
    localparam int T_ACCESS_PS   = 15000;
    localparam int T_CYCLE_PS    = 15000;
    localparam int T_WRITE_PS    = 10000;
    localparam int T_DSETUP_PS   = 7000;
    localparam int T_OE_WE_PS    = 4000;
    localparam int T_HIZ_PS      = 7000;
    // Least times round up
    localparam int ACCESS_CYC = (T_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYC  = (T_WRITE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DSETUP_CYC = (T_DSETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OE_WE_CYC  = (T_OE_WE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HIZ_CYC    = (T_HIZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYCLE_CYC  = (T_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W      = 4;

    typedef enum logic [2:0] {
        ASRC_IDLE  = 3'b000,
        ASRC_SETUP = 3'b001,
        ASRC_READ  = 3'b011,
        ASRC_WRITE = 3'b010,
        ASRC_REC   = 3'b110
    } asrc_state_e;
endpackage

// file: hdl/asrc_host.sv
// Host controller for an asynchronous 256K x 16 static RAM.
// Assumes the memory pins are wired directly; data pins are split into in/out/enable.
`timescale 1ns/1ps
module asrc_host (
    // Clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    // User request
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire logic                               req_write,
    input  wire logic [asrc_pkg::ADDR_W-1:0]        req_addr,
    input  wire logic [asrc_pkg::DATA_W-1:0]        req_wdata,
    input  wire logic [asrc_pkg::LANES-1:0]         req_lanes,
    // Read answer
    output logic                                    rsp_valid,
    output logic [asrc_pkg::DATA_W-1:0]             rsp_rdata,
    // Memory pins
    output logic [asrc_pkg::ADDR_W-1:0]             word_address,
    output logic                                    chip_select_n,
    output logic                                    output_enable_n,
    output logic                                    write_enable_n,
    output logic                                    lower_byte_n,
    output logic                                    upper_byte_n,
    input  wire logic [asrc_pkg::DATA_W-1:0]        data_pins_in,
    output logic [asrc_pkg::DATA_W-1:0]             data_pins_out,
    output logic                                    data_pins_oe_n
);
    typedef struct packed {
        asrc_pkg::asrc_state_e              st;
        logic [asrc_pkg::CNT_W-1:0]         cnt;
        logic                               wr;
        logic [asrc_pkg::ADDR_W-1:0]        addr;
        logic [asrc_pkg::DATA_W-1:0]        wdata;
        logic [asrc_pkg::LANES-1:0]         lanes_n;
        logic                               cs_n;
        logic                               oe_n;
        logic                               we_n;
        logic                               drv_n;
        logic                               rvalid;
        logic [asrc_pkg::DATA_W-1:0]        rdata;
        logic [asrc_pkg::DATA_W-1:0]        smp1;
        logic [asrc_pkg::DATA_W-1:0]        smp2;
    } asrc_regs_s;

    asrc_regs_s r;
    asrc_regs_s next_r;

    // Read lane selection held with the request; declared before the logic that reads it
    logic [asrc_pkg::LANES-1:0] req_lanes_q;

    function automatic logic [asrc_pkg::CNT_W-1:0] asrc_cyc(input int n);
        asrc_cyc = asrc_pkg::CNT_W'(n);
    endfunction

    initial begin
        if (asrc_pkg::ACCESS_CYC + 2 >= (1 << asrc_pkg::CNT_W)) begin
            $error("asrc_host: access count does not fit counter");
        end
    end

    always_comb begin
        next_r        = r;
        next_r.rvalid = 1'b0;
        // Read data passes two flops; pins are outside the clock domain
        next_r.smp1   = data_pins_in;
        next_r.smp2   = r.smp1;
        if (r.cnt != '0) begin
            next_r.cnt = r.cnt - asrc_cyc(1);
        end
        unique case (r.st)
            asrc_pkg::ASRC_IDLE: begin
                if (req_valid) begin
                    // Address and write lanes settle before any strobe falls; read lanes fall with select, see [R2] [R11]
                    next_r.st      = asrc_pkg::ASRC_SETUP;
                    next_r.wr      = req_write;
                    next_r.addr    = req_addr;
                    next_r.wdata   = req_wdata;
                    next_r.lanes_n = req_write ? ~req_lanes : '1;
                    next_r.cs_n    = 1'b1;
                    next_r.oe_n    = 1'b1;
                    next_r.cnt     = asrc_cyc(asrc_pkg::OE_WE_CYC); // see [R16]
                end
            end
            asrc_pkg::ASRC_SETUP: begin
                if (r.cnt == '0) begin
                    next_r.cs_n = 1'b0;
                    if (r.wr) begin
                        // Host drives data only once output enable has long been high, see [R4] [R13]
                        next_r.st    = asrc_pkg::ASRC_WRITE;
                        next_r.we_n  = 1'b0; // see [R5] [R6]
                        next_r.drv_n = 1'b0;
                        next_r.cnt   = asrc_cyc(asrc_pkg::WRITE_CYC); // see [R10] [R12]
                    end else begin
                        // Write enable never falls on a read; bus released, see [R1] [R19]
                        next_r.st      = asrc_pkg::ASRC_READ;
                        next_r.oe_n    = 1'b0;
                        next_r.lanes_n = ~req_lanes_q;
                        next_r.cnt     = asrc_cyc(asrc_pkg::ACCESS_CYC + 2); // see [R20]
                    end
                end
            end
            asrc_pkg::ASRC_READ: begin
                if (r.cnt == '0) begin
                    // Sample from the synchroniser output after access time, see [R20] [R21]
                    next_r.rvalid  = 1'b1;
                    next_r.rdata   = r.smp2;
                    next_r.st      = asrc_pkg::ASRC_REC;
                    next_r.cs_n    = 1'b1;
                    next_r.oe_n    = 1'b1;
                    next_r.lanes_n = '1; // see [R3] [R17]
                    next_r.cnt     = asrc_cyc(asrc_pkg::HIZ_CYC);
                end
            end
            asrc_pkg::ASRC_WRITE: begin
                if (r.cnt == '0) begin
                    // Write enable rise ends the write; data held through it, see [R7] [R8] [R9]
                    next_r.we_n    = 1'b1;
                    next_r.st      = asrc_pkg::ASRC_REC;
                    next_r.cnt     = asrc_cyc(asrc_pkg::CYCLE_CYC);
                end
            end
            asrc_pkg::ASRC_REC: begin
                // Data driver dropped one cycle (20 ns) after the ending edge, outside the 3 ns window
                next_r.drv_n   = 1'b1; // see [R14]
                next_r.cs_n    = 1'b1;
                next_r.lanes_n = '1;
                if (r.cnt == '0) begin
                    next_r.st = asrc_pkg::ASRC_IDLE;
                end
            end
            default: begin
                next_r.st = asrc_pkg::ASRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r         <= '0;
            r.st      <= asrc_pkg::ASRC_IDLE;
            r.cs_n    <= 1'b1;
            r.oe_n    <= 1'b1;
            r.we_n    <= 1'b1;
            r.drv_n   <= 1'b1;
            r.lanes_n <= '1;
            req_lanes_q <= '0;
        end else begin
            r <= next_r;
            if (r.st == asrc_pkg::ASRC_IDLE && req_valid) begin
                req_lanes_q <= req_lanes;
            end
        end
    end

    assign req_ready       = (r.st == asrc_pkg::ASRC_IDLE);
    assign rsp_valid       = r.rvalid;
    assign rsp_rdata       = r.rdata;
    assign word_address    = r.addr; // see [R18]
    assign chip_select_n   = r.cs_n;
    assign output_enable_n = r.oe_n;
    assign write_enable_n  = r.we_n; // see [R15]
    assign lower_byte_n    = r.lanes_n[0];
    assign upper_byte_n    = r.lanes_n[1];
    assign data_pins_out   = r.wdata;
    assign data_pins_oe_n  = r.drv_n;
endmodule

// file: verification/asrc_host_assertions.sv
// Checker for the static RAM host pins and request handshake.
// Assumes it is bound into asrc_host and sees only its ports.
`timescale 1ns/1ps
module asrc_host_assertions (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Request side
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic        rsp_valid,
    // Memory pins
    input wire logic [17:0] word_address,
    input wire logic        chip_select_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        data_pins_oe_n,
    input wire logic [15:0] data_pins_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_read_we_high: assert property (!output_enable_n |-> write_enable_n)
        else $error("write enable low during read");
    chk_addr_at_select: assert property ($fell(chip_select_n) |-> $stable(word_address))
        else $error("address moved as select fell");
    chk_write_selected: assert property (!write_enable_n |-> !chip_select_n)
        else $error("write enable low while deselected");
    chk_addr_hold: assert property (!write_enable_n |=> $stable(word_address))
        else $error("address moved before write end");
    chk_data_setup: assert property (!write_enable_n |=>
        !data_pins_oe_n && $stable(data_pins_out))
        else $error("write data not held to write end");
    chk_oe_before_we: assert property ($fell(write_enable_n) |-> $past(output_enable_n))
        else $error("outputs enabled as write began");
    chk_no_drive_read: assert property (!output_enable_n |-> data_pins_oe_n)
        else $error("host drives bus during read");
    chk_bus_release: assert property ($rose(write_enable_n) |=> data_pins_oe_n)
        else $error("bus not released after write");
    // Take edge, one setup wait, strobe edge, three access counts, then the registered pulse
    chk_read_latency: assert property (req_valid && req_ready && !req_write |-> ##7 rsp_valid)
        else $error("read answer late or early");
    chk_we_width: assert property ($fell(write_enable_n) |-> ##[1:3] write_enable_n)
        else $error("write pulse too long");
endmodule
bind asrc_host asrc_host_assertions chk_u (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .rsp_valid(rsp_valid),
    .word_address(word_address), .chip_select_n(chip_select_n), .data_pins_out(data_pins_out),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .data_pins_oe_n(data_pins_oe_n));

// file: verification/asrc_sram_model.sv
// Behavioural 256K x 16 static RAM on the host pins.
// Assumes zero pin delays; host samples on its own clock.
`timescale 1ns/1ps
module asrc_sram_model (
    // Pins from the host
    input wire logic [17:0] word_address,
    input wire logic        chip_select_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        lower_byte_n,
    input wire logic        upper_byte_n,
    input wire logic [15:0] host_data,
    input wire logic        host_oe_n,
    // Resolved bus
    output logic [15:0]     data_pins_in
);
    logic [15:0] mem [0:262143];
    logic        rd_lo;
    logic        rd_hi;
    logic        wr;
    // Deselect or write enable low floats every lane
    assign rd_lo = !chip_select_n && write_enable_n && !output_enable_n && !lower_byte_n;
    assign rd_hi = !chip_select_n && write_enable_n && !output_enable_n && !upper_byte_n;
    assign wr = !chip_select_n && !write_enable_n && !(lower_byte_n && upper_byte_n);
    always @* begin
        // No pull-ups: a floating bus shows the inverse of the host's data output word; a driven bus shows the word itself
        data_pins_in = host_oe_n ? ~host_data : host_data;
        if (rd_lo) data_pins_in[7:0] = host_oe_n ? mem[word_address][7:0] : 8'hXX;
        if (rd_hi) data_pins_in[15:8] = host_oe_n ? mem[word_address][15:8] : 8'hXX;
        if (wr && !lower_byte_n) mem[word_address][7:0] = data_pins_in[7:0];
        if (wr && !upper_byte_n) mem[word_address][15:8] = data_pins_in[15:8];
    end
endmodule

// file: verification/tb_asrc_host.sv
// Self-checking bench for the static RAM host controller.
// Assumes the behavioural RAM model on the pin side.
`timescale 1ns/1ps
module tb_asrc_host;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [17:0] req_addr = 18'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_lanes = 2'h0;
    logic        req_ready, rsp_valid, cs_n, oe_n, we_n, lb_n, ub_n, d_oe_n;
    logic [15:0] rsp_rdata, d_in, d_out, rd;
    logic [17:0] addr;
    int          num_errors = 0;
    int          num_checks = 0;
    always #10 sys_clk = ~sys_clk;
    asrc_host dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_address(addr), .chip_select_n(cs_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .lower_byte_n(lb_n), .upper_byte_n(ub_n),
        .data_pins_in(d_in), .data_pins_out(d_out), .data_pins_oe_n(d_oe_n));
    asrc_sram_model mem_u (.word_address(addr), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .lower_byte_n(lb_n), .upper_byte_n(ub_n), .host_data(d_out),
        .host_oe_n(d_oe_n), .data_pins_in(d_in));
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One request; valid held until the edge that takes it
    task automatic issue(input logic w, input logic [17:0] a, input logic [15:0] d,
                         input logic [1:0] ln);
        int n;
        n = 0;
        {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, ln};
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (!w && rsp_valid !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 40) check16(16'hDEAD, 16'h0000);
        rd = rsp_rdata;
    endtask
    task automatic t_reset();
        check16({8'h00, cs_n, oe_n, we_n, lb_n, ub_n, d_oe_n, req_ready, rsp_valid}, 16'h00FE);
    endtask
    task automatic t_word();
        issue(1'b1, 18'h3FFFF, 16'hBEEF, 2'h3);
        issue(1'b1, 18'h00000, 16'h1234, 2'h3);
        issue(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
        check16(rd, 16'hBEEF);
        issue(1'b0, 18'h00000, 16'h0000, 2'h3);
        check16(rd, 16'h1234);
    endtask
    task automatic t_lanes();
        issue(1'b1, 18'h00155, 16'hAAAA, 2'h3);
        issue(1'b1, 18'h00155, 16'h0011, 2'h1);
        issue(1'b1, 18'h00155, 16'h2200, 2'h2);
        issue(1'b0, 18'h00155, 16'h0000, 2'h3);
        check16(rd, 16'h2211);
        issue(1'b0, 18'h00155, 16'h0000, 2'h1);
        check16({8'h00, rd[7:0]}, 16'h0011);
    endtask
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        t_reset();
        rst = 1'b0;
        t_word();
        t_lanes();
        summarize();
    end
endmodule
